// *** common/ces_pkg.sv ***
// constants and types shared by the enable / standby / status block
// assumes a byte-wide register port and a protocol engine on the same clock
package ces_pkg;

    // register byte offsets on the 8-bit address port
    localparam logic [7:0] CES_OFF_CTRL = 8'hd8;   // general control
    localparam logic [7:0] CES_OFF_STAT = 8'hd9;   // can_general_status, read only
    localparam logic [7:0] CES_OFF_IFLG = 8'hda;   // sticky interrupt flags
    localparam logic [7:0] CES_OFF_IMSK = 8'hdb;   // interrupt mask, same layout

    // control register fields
    localparam int CES_CTRL_SRST = 0;               // soft_reset_req, self clearing
    localparam int CES_CTRL_ENA = 1;                // enable_standby_cmd

    // can_general_status fields, bits 7 and 5 unused and read zero
    localparam int CES_ST_ERROR_PASSIVE_FLAG = 0;                 // error_passive_flag
    localparam int CES_ST_BUS_OFF_FLAG = 1;                 // bus_off_flag
    localparam int CES_ST_ENABLED_FLAG = 2;                 // enabled_flag
    localparam int CES_ST_RXB = 3;                  // rx_active_flag
    localparam int CES_ST_TXB = 4;                  // tx_active_flag
    localparam int CES_ST_OVR = 6;                  // overload_active_flag

    // interrupt flag field
    localparam int CES_IF_BUS_OFF_FLAG = 6;                 // bus_off_irq_flag

    // reset values
    localparam logic [7:0] CES_RST_REG = 8'h00;     // every register resets to zero
    localparam logic CES_RECESSIVE = 1'b1;          // idle level of the bus

    // recessive bits needed before the channel may join the bus
    localparam int CES_RECESSIVE_BITS = 11;
    localparam int CES_CNT_W = 4;                   // counter width for that figure

    // channel mode states
    typedef enum logic [1:0] {
        CES_ST_DISABLED = 2'b00,                    // standby, frozen
        CES_ST_WAIT_IDLE = 2'b01,                   // counting recessive bits
        CES_ST_ENABLED = 2'b10,                     // on the bus
        CES_ST_STOPPING = 2'b11                     // finishing a transmission
    } ces_mode_t;

endpackage : ces_pkg

// *** design/ces_pin_sync.sv ***
// three-stage synchroniser for the receive pin
// assumes an asynchronous input; output moves once stages two and three agree
module ces_pin_sync #(
    parameter logic RESET_LEVEL = 1'b1
) (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic pin_i,
    output logic level_o
);

    logic s1_r;  // metastable stage, only s2_r reads it
    logic s2_r;
    logic s3_r;
    logic level_nxt;

    // change accepted only on agreement of the settled stages
    always_comb begin
        level_nxt = level_o;
        if (s2_r == s3_r) begin
            level_nxt = s3_r;
        end
    end

    // registers only
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s1_r <= RESET_LEVEL;
            s2_r <= RESET_LEVEL;
            s3_r <= RESET_LEVEL;
            level_o <= RESET_LEVEL;
        end else begin
            s1_r <= pin_i;
            s2_r <= s1_r;
            s3_r <= s2_r;
            level_o <= level_nxt;
        end
    end

endmodule : ces_pin_sync

// *** design/ces_core.sv ***
// enable / standby control, soft reset and general status of the can channel
// assumes the protocol engine shares clock_i and gives one bit_tick_i per bit
//
// Our own choice: the strobed register port.
module ces_core #(
    parameter int RECESSIVE_BITS = ces_pkg::CES_RECESSIVE_BITS
) (
    input wire logic clock_i,
    input wire logic resetn_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wr_data_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rd_data_o,
    input wire logic can_rx_i,
    output logic can_tx_o,
    input wire logic core_tx_i,
    input wire logic bit_tick_i,
    input wire logic tx_frame_active_i,
    input wire logic rx_frame_active_i,
    input wire logic overload_sending_i,
    input wire logic bus_off_i,
    input wire logic error_passive_i,
    output logic rx_enable_o,
    output logic freeze_o,
    output logic engine_reset_o,
    output logic can_rx_o,
    output logic irq_o
);

    // counter must hold RECESSIVE_BITS - 1
    if (RECESSIVE_BITS < 1 || RECESSIVE_BITS > (1 << ces_pkg::CES_CNT_W)) begin : g_chk
        $error("RECESSIVE_BITS out of range");
    end

    localparam logic [ces_pkg::CES_CNT_W-1:0] CNT_LAST =
        ces_pkg::CES_CNT_W'(RECESSIVE_BITS - 1);

    // reset release copy
    logic rst_a_r;
    logic rst_n_r;
    logic rx_lvl;                   // settled receive level

    // register bus decode helper
    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction : hit

    // two-flop release of the asynchronous reset
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rst_a_r <= 1'b0;
            rst_n_r <= 1'b0;
        end else begin
            rst_a_r <= 1'b1;
            rst_n_r <= rst_a_r;
        end
    end

    ces_pin_sync #(
        .RESET_LEVEL(ces_pkg::CES_RECESSIVE)
    ) u_rx_sync (
        .clock_i(clock_i),
        .rst_n_i(rst_n_r),
        .pin_i(can_rx_i),
        .level_o(rx_lvl)
    );

    // control state
    logic ena_cmd_r, ena_cmd_nxt;   // enable_standby_cmd
    logic srst_r, srst_nxt;         // soft_reset_req, high one cycle
    ces_pkg::ces_mode_t state_r, state_nxt;
    logic [ces_pkg::CES_CNT_W-1:0] rec_cnt_r, rec_cnt_nxt;
    logic [7:0] iflg_r, iflg_nxt;   // sticky interrupt flags
    logic [7:0] imsk_r, imsk_nxt;   // interrupt mask
    logic bus_off_flag_prev_r, bus_off_flag_prev_nxt;
    logic wr_ctrl;
    logic bus_off_flag_rise;

    assign wr_ctrl = wr_i && hit(addr_i, ces_pkg::CES_OFF_CTRL);
    assign bus_off_flag_rise = bus_off_i && !bus_off_flag_prev_r;

    // next values of control state; soft reset clears it like a hardware reset, except bus_off_flag_prev_r
    always_comb begin
        ena_cmd_nxt = ena_cmd_r;
        srst_nxt = 1'b0;
        state_nxt = state_r;
        rec_cnt_nxt = rec_cnt_r;
        iflg_nxt = iflg_r;
        imsk_nxt = imsk_r;
        bus_off_flag_prev_nxt = bus_off_i;
        // mode sequencing
        case (state_r)
            ces_pkg::CES_ST_DISABLED: begin
                rec_cnt_nxt = '0;
                if (ena_cmd_r) begin
                    state_nxt = ces_pkg::CES_ST_WAIT_IDLE;
                end
            end
            ces_pkg::CES_ST_WAIT_IDLE: begin
                if (!ena_cmd_r) begin
                    state_nxt = ces_pkg::CES_ST_DISABLED;
                end else if (bit_tick_i) begin
                    if (rx_lvl != ces_pkg::CES_RECESSIVE) begin
                        rec_cnt_nxt = '0;
                    end else if (rec_cnt_r == CNT_LAST) begin
                        state_nxt = ces_pkg::CES_ST_ENABLED;
                    end else begin
                        rec_cnt_nxt = rec_cnt_r + 1'b1;
                    end
                end
            end
            ces_pkg::CES_ST_ENABLED: begin
                if (!ena_cmd_r) begin
                    state_nxt = ces_pkg::CES_ST_STOPPING;
                end
            end
            ces_pkg::CES_ST_STOPPING: begin
                if (!tx_frame_active_i) begin
                    state_nxt = ces_pkg::CES_ST_DISABLED;
                end
            end
            default: begin
                state_nxt = ces_pkg::CES_ST_DISABLED;
            end
        endcase
        // register writes
        if (wr_ctrl) begin
            ena_cmd_nxt = wr_data_i[ces_pkg::CES_CTRL_ENA];
            srst_nxt = wr_data_i[ces_pkg::CES_CTRL_SRST];
        end
        if (wr_i && hit(addr_i, ces_pkg::CES_OFF_IMSK)) begin
            imsk_nxt = wr_data_i & (8'h01 << ces_pkg::CES_IF_BUS_OFF_FLAG);
        end
        if (wr_i && hit(addr_i, ces_pkg::CES_OFF_IFLG)) begin
            iflg_nxt = iflg_r & ~wr_data_i;
        end
        // only the entry into bus-off sets the flag; set wins over clear
        if (bus_off_flag_rise) begin
            iflg_nxt[ces_pkg::CES_IF_BUS_OFF_FLAG] = 1'b1;
        end
        // soft reset clears controller state and drops itself
        if (srst_r) begin
            ena_cmd_nxt = 1'b0;
            srst_nxt = 1'b0;
            state_nxt = ces_pkg::CES_ST_DISABLED;
            rec_cnt_nxt = '0;
            iflg_nxt = ces_pkg::CES_RST_REG;
            imsk_nxt = ces_pkg::CES_RST_REG;
        end
    end

    // control registers
    always_ff @(posedge clock_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            ena_cmd_r <= 1'b0;
            srst_r <= 1'b0;
            state_r <= ces_pkg::CES_ST_DISABLED;
            rec_cnt_r <= '0;
            iflg_r <= ces_pkg::CES_RST_REG;
            imsk_r <= ces_pkg::CES_RST_REG;
            bus_off_flag_prev_r <= 1'b0;
        end else begin
            ena_cmd_r <= ena_cmd_nxt;
            srst_r <= srst_nxt;
            state_r <= state_nxt;
            rec_cnt_r <= rec_cnt_nxt;
            iflg_r <= iflg_nxt;
            imsk_r <= imsk_nxt;
            bus_off_flag_prev_r <= bus_off_flag_prev_nxt;
        end
    end

    // output and status state
    logic [7:0] stat_r, stat_nxt;   // can_general_status image
    logic tx_nxt, rxen_nxt, frz_nxt, erst_nxt, irq_nxt, rxo_nxt;
    logic [7:0] rd_nxt;
    logic on_bus;

    // transmitter keeps its path while finishing the last frame
    assign on_bus = (state_r == ces_pkg::CES_ST_ENABLED) || (state_r == ces_pkg::CES_ST_STOPPING);

    // next values of pins, status and read data
    always_comb begin
        stat_nxt = ces_pkg::CES_RST_REG;
        stat_nxt[ces_pkg::CES_ST_OVR] = overload_sending_i;
        stat_nxt[ces_pkg::CES_ST_TXB] = tx_frame_active_i;
        stat_nxt[ces_pkg::CES_ST_RXB] = rx_frame_active_i;
        stat_nxt[ces_pkg::CES_ST_ERROR_PASSIVE_FLAG] = error_passive_i;
        stat_nxt[ces_pkg::CES_ST_BUS_OFF_FLAG] = bus_off_i;
        stat_nxt[ces_pkg::CES_ST_ENABLED_FLAG] = on_bus;
        tx_nxt = on_bus ? core_tx_i : ces_pkg::CES_RECESSIVE;
        rxen_nxt = (state_r == ces_pkg::CES_ST_ENABLED);
        rxo_nxt = rxen_nxt ? rx_lvl : ces_pkg::CES_RECESSIVE;
        frz_nxt = !on_bus;
        erst_nxt = srst_r;
        irq_nxt = |(iflg_nxt & imsk_nxt);
        // read port; registers stay reachable in standby
        rd_nxt = ces_pkg::CES_RST_REG;
        if (rd_i) begin
            if (hit(addr_i, ces_pkg::CES_OFF_CTRL)) begin
                rd_nxt[ces_pkg::CES_CTRL_ENA] = ena_cmd_r;
            end else if (hit(addr_i, ces_pkg::CES_OFF_STAT)) begin
                rd_nxt = stat_r;
            end else if (hit(addr_i, ces_pkg::CES_OFF_IFLG)) begin
                rd_nxt = iflg_r;
            end else if (hit(addr_i, ces_pkg::CES_OFF_IMSK)) begin
                rd_nxt = imsk_r;
            end
        end
    end

    // output registers; engine reset held during hardware reset
    always_ff @(posedge clock_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            stat_r <= ces_pkg::CES_RST_REG;
            can_tx_o <= ces_pkg::CES_RECESSIVE;
            rx_enable_o <= 1'b0;
            can_rx_o <= ces_pkg::CES_RECESSIVE;
            freeze_o <= 1'b1;
            engine_reset_o <= 1'b1;
            irq_o <= 1'b0;
            rd_data_o <= ces_pkg::CES_RST_REG;
        end else begin
            stat_r <= stat_nxt;
            can_tx_o <= tx_nxt;
            rx_enable_o <= rxen_nxt;
            can_rx_o <= rxo_nxt;
            freeze_o <= frz_nxt;
            engine_reset_o <= erst_nxt;
            irq_o <= irq_nxt;
            rd_data_o <= rd_nxt;
        end
    end

    // checks
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!rst_n_r);

    a_tx_recessive: assert property (
        (state_r == ces_pkg::CES_ST_DISABLED) |=> can_tx_o)
        else $error("transmit not recessive in standby");

    a_enable_idle: assert property (
        $rose(state_r == ces_pkg::CES_ST_ENABLED) |->
        $past(rec_cnt_r) == CNT_LAST && $past(bit_tick_i) && $past(rx_lvl))
        else $error("enabled without enough recessive bits");

    a_stop_waits: assert property (
        state_r == ces_pkg::CES_ST_STOPPING && tx_frame_active_i && !srst_r
        |=> state_r == ces_pkg::CES_ST_STOPPING)
        else $error("standby cut a transmission");

    a_flag_clear: assert property (
        $fell(stat_r[ces_pkg::CES_ST_ENABLED_FLAG]) |->
        $past(state_r, 2) == ces_pkg::CES_ST_STOPPING || $past(srst_r, 2))
        else $error("enabled flag dropped before freeze");

    a_soft_reset: assert property (
        wr_ctrl && wr_data_i[ces_pkg::CES_CTRL_SRST] |=>
        srst_r ##1 (!srst_r && engine_reset_o && state_r == ces_pkg::CES_ST_DISABLED))
        else $error("soft reset did not act or self clear");

    a_bus_off_flag_entry: assert property (
        bus_off_flag_rise && !srst_r |=> iflg_r[ces_pkg::CES_IF_BUS_OFF_FLAG])
        else $error("bus-off entry lost");

    a_bus_off_flag_stay: assert property (
        !iflg_r[ces_pkg::CES_IF_BUS_OFF_FLAG] && bus_off_i && bus_off_flag_prev_r
        |=> !iflg_r[ces_pkg::CES_IF_BUS_OFF_FLAG])
        else $error("bus-off flag set without entry");

    a_status_img: assert property (
        ##1 stat_r[ces_pkg::CES_ST_OVR] == $past(overload_sending_i)
        && stat_r[ces_pkg::CES_ST_TXB] == $past(tx_frame_active_i)
        && stat_r[ces_pkg::CES_ST_RXB] == $past(rx_frame_active_i)
        && stat_r[ces_pkg::CES_ST_ERROR_PASSIVE_FLAG] == $past(error_passive_i))
        else $error("status bits do not follow engine");

    a_status_read: assert property (
        rd_i && hit(addr_i, ces_pkg::CES_OFF_STAT) |=>
        rd_data_o == $past(stat_r) && rd_data_o[7] == 1'b0 && rd_data_o[5] == 1'b0)
        else $error("status read wrong");

    a_rx_gate: assert property (
        rx_enable_o |-> stat_r[ces_pkg::CES_ST_ENABLED_FLAG])
        else $error("receiver on while not enabled");

endmodule : ces_core

// *** verification/ces_bus_model.sv ***
// behavioural can bus seen through the transceiver, plus bit timing ticks
// assumes the bench shares clock_i; one bit time lasts TICK_DIV clocks
module ces_bus_model #(
    parameter int TICK_DIV = 5
) (
    input wire logic clock_i,
    input wire logic tx_i,
    input wire logic other_dom_i,
    output logic rx_o,
    output logic bit_tick_o
);
    timeunit 1ns;
    timeprecision 100ps;
    int div_cnt = 0; // position inside the bit time
    logic tick_r = 1'b0; // single driver behind the tick output
    assign bit_tick_o = tick_r;
    // wired-and: any node pulling dominant wins, idle bus rests recessive
    assign rx_o = tx_i & ~other_dom_i;
    // evenly spaced sample points, as a fixed bit timing would give
    always @(posedge clock_i) begin
        div_cnt <= (div_cnt == TICK_DIV - 1) ? 0 : div_cnt + 1;
        tick_r <= (div_cnt == TICK_DIV - 1);
    end
endmodule : ces_bus_model

// *** verification/tb_top.sv ***
// self-checking bench for the enable / standby / status block
// assumes ces_core and the bus model; short recessive count for speed
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int RB = 4; // shortened recessive count
    localparam int DIV = 5; // clocks per bit
    localparam logic [7:0] A_CT = ces_pkg::CES_OFF_CTRL;
    localparam logic [7:0] A_ST = ces_pkg::CES_OFF_STAT;
    localparam logic [7:0] A_IF = ces_pkg::CES_OFF_IFLG;
    localparam logic [7:0] A_IM = ces_pkg::CES_OFF_IMSK;
    logic clock = 1'b0, resetn = 1'b0, wr = 1'b0, rd = 1'b0, core_tx = 1'b1, other_dom = 1'b0;
    logic tx_act = 1'b0, rx_act = 1'b0, ovr = 1'b0, bus_off_flag = 1'b0, error_passive_flag = 1'b0;
    logic [7:0] addr = 8'h00, wr_data = 8'h00, rd_data, got;
    logic can_rx, can_tx, bit_tick, rx_en, freeze, eng_rst, rx_to_eng, irq;
    int err_total = 0, check_count = 0, cycles = 0;
    ces_core #(.RECESSIVE_BITS(RB)) dut (.clock_i(clock), .resetn_i(resetn), .addr_i(addr),
        .wr_data_i(wr_data), .wr_i(wr), .rd_i(rd), .rd_data_o(rd_data), .can_rx_i(can_rx),
        .can_tx_o(can_tx), .core_tx_i(core_tx), .bit_tick_i(bit_tick), .tx_frame_active_i(tx_act),
        .rx_frame_active_i(rx_act), .overload_sending_i(ovr), .bus_off_i(bus_off_flag),
        .error_passive_i(error_passive_flag), .rx_enable_o(rx_en), .freeze_o(freeze),
        .engine_reset_o(eng_rst), .can_rx_o(rx_to_eng), .irq_o(irq));
    ces_bus_model #(.TICK_DIV(DIV)) bus (.clock_i(clock), .tx_i(can_tx), .other_dom_i(other_dom),
        .rx_o(can_rx), .bit_tick_o(bit_tick));
    always #2 clock = ~clock;
    // hang guard, far above the few hundred cycles the run needs
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            print_verdict();
        end
    end
    task automatic print_verdict();
        $display("checks %0d, mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : print_verdict
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        addr <= a;
        wr_data <= d;
        wr <= 1'b1;
        @(posedge clock);
        wr <= 1'b0;
    endtask : wreg
    // read data stand only in the cycle after the strobe
    task automatic rreg(input logic [7:0] a);
        @(posedge clock);
        addr <= a;
        rd <= 1'b1;
        @(posedge clock);
        rd <= 1'b0;
        #1 got = rd_data;
    endtask : rreg
    function automatic logic pick(input int sel);
        return sel == 0 ? freeze : (sel == 1 ? eng_rst : irq);
    endfunction : pick
    // bounded wait on freeze (0), engine reset (1) or interrupt (2)
    task automatic wait_on(input int sel, input logic v);
        int n = 0;
        #1;
        while (pick(sel) !== v && n < 200) begin
            @(posedge clock);
            #1 n++;
        end
        chk({7'h00, pick(sel)}, {7'h00, v});
    endtask : wait_on
    function automatic logic [7:0] exp_st(input logic o, t, r, e, b, p);
        logic [7:0] s = 8'h00;
        s[ces_pkg::CES_ST_OVR] = o;
        s[ces_pkg::CES_ST_TXB] = t;
        s[ces_pkg::CES_ST_RXB] = r;
        s[ces_pkg::CES_ST_ENABLED_FLAG] = e;
        s[ces_pkg::CES_ST_BUS_OFF_FLAG] = b;
        s[ces_pkg::CES_ST_ERROR_PASSIVE_FLAG] = p;
        return s;
    endfunction : exp_st
    initial begin
        logic [4:0] rv;
        logic v;
        void'($urandom(32'he5cd));
        repeat (4) @(posedge clock);
        resetn <= 1'b1;
        repeat (3) @(posedge clock);
        rreg(A_ST);
        chk(got, ces_pkg::CES_RST_REG);
        wreg(A_ST, 8'hff);
        rreg(A_ST);
        chk(got, 8'h00);
        rreg(8'h42);
        chk(got, 8'h00);
        chk({5'h00, can_tx, rx_to_eng, rx_en}, 8'h06);
        // enable asked while another node holds the bus dominant
        @(posedge clock);
        other_dom <= 1'b1;
        wreg(A_CT, 8'h02);
        rreg(A_CT);
        chk(got, 8'h02);
        rreg(A_ST);
        chk(got, 8'h00);
        repeat (30 * DIV) @(posedge clock);
        #1 chk({7'h00, freeze}, 8'h01);
        @(posedge clock);
        other_dom <= 1'b0;
        repeat ((RB - 1) * DIV) @(posedge clock);
        #1 chk({7'h00, freeze}, 8'h01);
        wait_on(0, 1'b0);
        rreg(A_ST);
        chk(got, exp_st(0, 0, 0, 1, 0, 0));
        chk({7'h00, rx_en}, 8'h01);
        // random engine status while on the bus; mask is clear so no interrupt
        for (int i = 0; i < 24; i++) begin
            rv = 5'($urandom());
            v = 1'($urandom());
            @(posedge clock);
            {ovr, tx_act, rx_act, bus_off_flag, error_passive_flag} <= rv;
            core_tx <= v;
            @(posedge clock);
            #1 chk({7'h00, can_tx}, {7'h00, v});
            rreg(A_ST);
            chk(got, exp_st(rv[4], rv[3], rv[2], 1'b1, rv[1], rv[0]));
            chk({7'h00, irq}, 8'h00);
        end
        @(posedge clock);
        {ovr, tx_act, rx_act, bus_off_flag, error_passive_flag} <= 5'h00;
        core_tx <= 1'b1;
        other_dom <= 1'b1;
        repeat (8) @(posedge clock);
        #1 chk({7'h00, rx_to_eng}, 8'h00);
        // bus-off entry raises the flag once; staying there does not
        @(posedge clock);
        other_dom <= 1'b0;
        wreg(A_IF, 8'hff);
        wreg(A_IM, 8'h40);
        @(posedge clock);
        bus_off_flag <= 1'b1;
        wait_on(2, 1'b1);
        rreg(A_IF);
        chk(got, 8'h40);
        wreg(A_IF, 8'h40);
        rreg(A_IF);
        chk(got, 8'h00);
        chk({7'h00, irq}, 8'h00);
        rreg(A_ST);
        chk(got, exp_st(0, 0, 0, 1, 1, 0));
        @(posedge clock);
        bus_off_flag <= 1'b0;
        wreg(A_IM, 8'h00);
        @(posedge clock);
        bus_off_flag <= 1'b1;
        repeat (4) @(posedge clock);
        rreg(A_IF);
        chk(got, 8'h40);
        chk({7'h00, irq}, 8'h00);
        @(posedge clock);
        bus_off_flag <= 1'b0;
        tx_act <= 1'b1;
        rx_act <= 1'b0;
        // software sees the receiver idle before it asks for standby
        rreg(A_ST);
        chk(got, exp_st(0, 1, 0, 1, 0, 0));
        wreg(A_CT, 8'h00);
        repeat (12) @(posedge clock);
        #1 chk({7'h00, freeze}, 8'h00);
        rreg(A_ST);
        chk(got, exp_st(0, 1, 0, 1, 0, 0));
        @(posedge clock);
        tx_act <= 1'b0;
        wait_on(0, 1'b1);
        rreg(A_ST);
        chk(got, 8'h00);
        for (int i = 0; i < 8; i++) begin
            @(posedge clock);
            core_tx <= i[0];
            other_dom <= ~i[0];
            @(posedge clock);
            #1 chk({5'h00, can_tx, rx_to_eng, rx_en}, 8'h06);
        end
        wreg(A_IM, 8'h40);
        rreg(A_IM);
        chk(got, 8'h40);
        // soft reset pulse clears the controller and drops itself
        @(posedge clock);
        core_tx <= 1'b1;
        other_dom <= 1'b0;
        wreg(A_CT, 8'h02);
        wreg(A_CT, 8'h03);
        wait_on(1, 1'b1);
        wait_on(1, 1'b0);
        rreg(A_CT);
        chk(got, 8'h00);
        rreg(A_IM);
        chk(got, 8'h00);
        chk({7'h00, freeze}, 8'h01);
        // hardware reset in mid-run while an enable is pending
        wreg(A_CT, 8'h02);
        @(posedge clock);
        resetn <= 1'b0;
        #1 chk({5'h00, eng_rst, freeze, rx_en}, 8'h06);
        repeat (2) @(posedge clock);
        resetn <= 1'b1;
        repeat (3) @(posedge clock);
        #1 chk({7'h00, eng_rst}, 8'h00);
        rreg(A_CT);
        chk(got, 8'h00);
        // enable withdrawn while the idle bits are still being counted
        wreg(A_CT, 8'h02);
        wreg(A_CT, 8'h00);
        repeat (3 * RB * DIV) @(posedge clock);
        #1 chk({7'h00, freeze}, 8'h01);
        rreg(A_ST);
        chk(got, 8'h00);
        print_verdict();
    end
endmodule : tb_top
